// ### sim/scrb_assertions.sv
/*
 checker: pin and decoded output relations of the charger register bank.
 assumes it is bound to scrb_top and that everything runs on CLK.
*/
`timescale 1ns/1ps
`default_nettype none
module scrb_assertions
#(
  parameter TICKS_PER_S = 100
)
(
  // clocking
  input wire logic CLK,
  input wire logic RST_B,
  // bus pins
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  // device state
  input wire logic BATTERY_PRESENT_N_PIN,
  input wire logic ADAPTER_PRESENT,
  input wire logic REVERSE_MODE_ACTIVE,
  // decoded controls
  input wire logic GATE_DRIVE_SUPPLY_EN,
  input wire logic BATTERY_CURRENT_MONITOR_EN,
  input wire logic SYSTEM_POWER_MONITOR_EN,
  input wire logic ADC_EN,
  input wire logic POWER_GOOD_OUT,
  input wire logic GAUGE_CALIBRATION_DISCHARGE,
  input wire logic CHARGE_ENABLE,
  input wire logic WATCHDOG_SUSPENDED,
  input wire logic [15:0] CHARGE_CURRENT_OUT,
  input wire logic [15:0] CHARGE_VOLTAGE_OUT
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  wire mon = GATE_DRIVE_SUPPLY_EN && BATTERY_CURRENT_MONITOR_EN;
  ////////////////////////////////////////////////////////////////////////////
  sequence s_stop;
    SCL_IN && !SDA_IN ##1 SCL_IN && SDA_IN;
  endsequence
  sequence s_drive;
    $rose(SDA_OE);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  chk_oe_scl_low: assert property
    ($changed(SDA_OE) |-> !SCL_IN) else $error("data moved, clock high");
  chk_sda_low: assert property
    (SDA_OUT == 1'b0) else $error("data pin driven high");
  chk_ack_hold: assert property
    (s_drive |-> SDA_OE [*8]) else $error("low bit too short");
  chk_stop_quiet: assert property
    (s_stop |=> !SDA_OE [*8]) else $error("driven after stop");
  chk_mon_on: assert property
    (ADAPTER_PRESENT [*2] |-> mon && SYSTEM_POWER_MONITOR_EN && ADC_EN)
    else $error("monitors off with adapter");
  chk_mon_same: assert property
    (mon == ADC_EN && ADC_EN == SYSTEM_POWER_MONITOR_EN
     && GATE_DRIVE_SUPPLY_EN == BATTERY_CURRENT_MONITOR_EN)
    else $error("monitor enables disagree");
  chk_pg_rev: assert property
    (!REVERSE_MODE_ACTIVE [*2] |-> !POWER_GOOD_OUT)
    else $error("power good without reverse mode");
  chk_chg_valid: assert property
    (CHARGE_ENABLE && $stable(CHARGE_CURRENT_OUT)
     && $stable(CHARGE_VOLTAGE_OUT) && $stable(WATCHDOG_SUSPENDED)
     |-> CHARGE_CURRENT_OUT != 0 && CHARGE_VOLTAGE_OUT != 0
     && !WATCHDOG_SUSPENDED) else $error("charging without settings");
  chk_wdog_zero: assert property
    ($rose(WATCHDOG_SUSPENDED) |-> ##[0:2]
     (CHARGE_CURRENT_OUT == 16'h0000 && !CHARGE_ENABLE))
    else $error("expiry left current set");
  chk_cal_clear: assert property
    ($fell(BATTERY_PRESENT_N_PIN) |-> ##[2:10] !GAUGE_CALIBRATION_DISCHARGE)
    else $error("calibration not cleared");
  chk_rst_dec: assert property
    ($rose(RST_B) |-> mon && !CHARGE_ENABLE && !SDA_OE)
    else $error("bad state after reset");
endmodule
bind scrb_top scrb_assertions #(.TICKS_PER_S(TICKS_PER_S)) u_chk (
  .CLK(CLK), .RST_B(RST_B), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .BATTERY_PRESENT_N_PIN(BATTERY_PRESENT_N_PIN),
  .ADAPTER_PRESENT(ADAPTER_PRESENT), .REVERSE_MODE_ACTIVE(REVERSE_MODE_ACTIVE),
  .GATE_DRIVE_SUPPLY_EN(GATE_DRIVE_SUPPLY_EN),
  .BATTERY_CURRENT_MONITOR_EN(BATTERY_CURRENT_MONITOR_EN),
  .SYSTEM_POWER_MONITOR_EN(SYSTEM_POWER_MONITOR_EN), .ADC_EN(ADC_EN),
  .POWER_GOOD_OUT(POWER_GOOD_OUT),
  .GAUGE_CALIBRATION_DISCHARGE(GAUGE_CALIBRATION_DISCHARGE),
  .CHARGE_ENABLE(CHARGE_ENABLE), .WATCHDOG_SUSPENDED(WATCHDOG_SUSPENDED),
  .CHARGE_CURRENT_OUT(CHARGE_CURRENT_OUT),
  .CHARGE_VOLTAGE_OUT(CHARGE_VOLTAGE_OUT)
);
`default_nettype wire

// ### sim/scrb_host.sv
/*
 bus master model: word write and word read with a 160 ns bit clock.
 assumes an open-drain data line pulled up outside; clock idles high.
*/
`timescale 1ns/1ps
`default_nettype none
module scrb_host
(
  // clocking
  input wire logic clk,
  // bus pins, sda_drv low pulls the line
  input wire logic sda,
  output logic scl,
  output logic sda_drv,
  // result of the last transfer
  output logic done,
  output logic [19:0] res
);
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
    done = 1'b0;
    res = 20'h00000;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bx(input logic b, output logic r);
    wt(5);
    sda_drv <= b;
    wt(5);
    scl <= 1'b1;
    wt(3);
    r = sda;
    wt(3);
    scl <= 1'b0;
  endtask
  // start when stp is low, stop otherwise; wait lets the slave let go
  task automatic edge_c(input logic stp);
    wt(6);
    sda_drv <= ~stp;
    wt(4);
    scl <= 1'b1;
    wt(4);
    sda_drv <= stp;
    wt(4);
    if (!stp)
      scl <= 1'b0;
  endtask
  // msb first, ninth bit from receiver
  task automatic tx(input logic [7:0] d, output logic k);
    logic r;
    for (int j = 7; j >= 0; j--)
      bx(d[j], r);
    bx(1'b1, k);
  endtask
  // low byte acked, high byte not
  task automatic rx(input logic nk, output logic [7:0] d);
    logic r;
    for (int j = 7; j >= 0; j--)
      bx(1'b1, d[j]);
    bx(nk, r);
  endtask
  task automatic post(input logic [19:0] v);
    res <= v;
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
  endtask
  task automatic write_word(input logic [6:0] a, input logic [7:0] c,
                            input logic [15:0] d);
    logic [3:0] k;
    edge_c(1'b0);
    tx({a, 1'b0}, k[3]);
    tx(c, k[2]);
    tx(d[7:0], k[1]);
    tx(d[15:8], k[0]);
    edge_c(1'b1);
    post({k, 16'h0000});
  endtask
  task automatic read_word(input logic [6:0] a, input logic [7:0] c);
    logic [3:0] k;
    logic [15:0] d;
    edge_c(1'b0);
    tx({a, 1'b0}, k[3]);
    tx(c, k[2]);
    edge_c(1'b0);
    tx({a, 1'b1}, k[1]);
    rx(1'b0, d[7:0]);
    rx(1'b1, d[15:8]);
    edge_c(1'b1);
    k[0] = 1'b0;
    post({k, d});
  endtask
endmodule
`default_nettype wire

// ### sim/tb.sv
/*
 self-checking bench of the charger register bank through its bus pins.
 assumes scrb_host as bus master and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scrb_defines.vh"
module tb;
  localparam logic [15:0] MK = 16'h0033; // arbitrary identity value
  localparam logic [15:0] PK = 16'h00C4; // arbitrary identity value
  localparam logic [6:0] AD = `SCRB_SLAVE_ADDR;
  localparam logic [7:0] C12 = `SCRB_CMD_CTRL_A;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic batt_n = 1'b1;
  logic adp = 1'b1;
  logic rev = 1'b0;
  logic [15:0] ro_in [0:6];
  logic [15:0] st_rc = 16'h0000;
  logic [15:0] th_rc = 16'h0000;
  logic [31:0] rnd = 32'hD64E;
  logic [19:0] exp_q [$];
  logic [15:0] w;
  logic [7:0] c;
  int fail_count = 0;
  int n_tests = 0;
  int i;
  wire scl, sda_drv, oe, so, chg, wds, hd;
  wire [13:0] obs;
  wire [15:0] cur, vlt;
  wire [19:0] hr;
  // pull-up: the line is low only while someone pulls it
  wire sda = sda_drv & ~oe;
  always #5 CLK = ~CLK;
  scrb_top #(.TICKS_PER_S(100), .MAKER_CODE(MK), .PART_CODE(PK)) u_dut (
    .CLK(CLK), .RST_B(RST_B), .CE(1'b1), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(so), .SDA_OE(oe), .BATTERY_PRESENT_N_PIN(batt_n),
    .ADAPTER_PRESENT(adp), .REVERSE_MODE_ACTIVE(rev),
    .STATE_FLAGS_IN(ro_in[0]), .STATE_FLAGS_RC(st_rc),
    .THR_FLAGS_IN(ro_in[1]), .THR_FLAGS_RC(th_rc), .IN_LIMIT_IN(ro_in[2]),
    .VBUS_ADC_IN(ro_in[3]), .BATTERY_CURRENT_MONITOR_ADC_IN(ro_in[4]), .IIN_ADC_IN(ro_in[5]),
    .VSYS_ADC_IN(ro_in[6]), .GATE_DRIVE_SUPPLY_EN(obs[13]),
    .BATTERY_CURRENT_MONITOR_EN(obs[12]), .SYSTEM_POWER_MONITOR_EN(obs[11]),
    .ADC_EN(obs[10]), .POWER_GOOD_OUT(obs[9]), .AUDIO_BAND_AVOID(obs[8]),
    .SWITCH_RATE_SELECT(obs[7]), .BYPASS_RIPPLE_REDUCE(obs[6]),
    .SHORT_RETRY_OFF(obs[5]), .GAUGE_CALIBRATION_DISCHARGE(obs[4]),
    .ADAPTER_SENSE_GAIN(obs[3]), .BATTERY_SENSE_GAIN(obs[2]),
    .LINEAR_PRECHARGE_ENABLE(obs[1]), .INPUT_CURRENT_REGULATION_ON(obs[0]),
    .CHARGE_ENABLE(chg), .WATCHDOG_SUSPENDED(wds),
    .CHARGE_CURRENT_OUT(cur), .CHARGE_VOLTAGE_OUT(vlt));
  scrb_host u_host (.clk(CLK), .sda(sda), .scl(scl), .sda_drv(sda_drv),
    .done(hd), .res(hr));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [13:0] dec(input logic [15:0] v);
    logic lp;
    lp = v[15] & ~adp;
    return {{4{~lp}}, v[11] & rev, v[10:8], v[6:1]};
  endfunction
  task automatic check(input logic [19:0] s, input logic [19:0] e);
    n_tests++;
    if (s !== e)
    begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] k,
                    input logic [15:0] d);
    exp_q.push_back({(a == AD) ? 4'h0 : 4'hF, 16'h0000});
    u_host.write_word(a, k, d);
  endtask
  task automatic rd(input logic [7:0] k, input logic [15:0] e);
    exp_q.push_back({4'h0, e});
    u_host.read_word(AD, k);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // an empty queue turns into a forced mismatch
  always @(posedge CLK)
  begin
    if (hd === 1'b1)
      check(hr, exp_q.size() ? exp_q.pop_front() : ~hr);
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (int k = 0; k < 7; k++)
      ro_in[k] = 16'h0000;
    repeat (16) @(posedge CLK);
    RST_B <= 1'b1;
    repeat (8) @(posedge CLK);
    check(obs, dec(`SCRB_CTRL_A_RST));
    rd(C12, `SCRB_CTRL_A_RST);
    rd(`SCRB_CMD_CHG_CUR, 16'h0000);
    rd(`SCRB_CMD_MAKER, MK);
    rd(`SCRB_CMD_PART, PK);
    rd(8'h40, 16'h0000);
    $display("reset test done");
    for (int k = 0; k < 19; k++)
    begin
      rnd = lfsr(rnd);
      c = 8'(k < 7 ? 48 + k : k < 12 ? 52 + k : 20 + k);
      if (k >= 12)
        ro_in[k - 12] <= rnd[15:0];
      wr(AD, c, k < 12 ? rnd[15:0] : ~rnd[15:0]);
      rd(c, rnd[15:0]);
    end
    rnd = lfsr(rnd);
    wr(AD, 8'h40, rnd[15:0]);
    rd(8'h40, 16'h0000);
    wr(7'h0A, C12, 16'h0000);
    exp_q.push_back({4'hE, 16'hFFFF});
    u_host.read_word(7'h0A, C12);
    rd(C12, `SCRB_CTRL_A_RST);
    st_rc <= 16'h0100;
    th_rc <= 16'h8001;
    @(posedge CLK);
    st_rc <= 16'h0000;
    th_rc <= 16'h0000;
    rd(`SCRB_CMD_STATE, ro_in[0] | 16'h0100);
    rd(`SCRB_CMD_STATE, ro_in[0]);
    rd(`SCRB_CMD_THR_STATE, ro_in[1] | 16'h8001);
    rd(`SCRB_CMD_THR_STATE, ro_in[1]);
    $display("map test done");
    for (int k = 0; k < 3; k++)
    begin
      rnd = lfsr(rnd);
      w = k == 0 ? 16'h0000 : k == 1 ? 16'hFF7F : rnd[15:0] & 16'hFF7F;
      wr(AD, C12, w);
      for (int j = 0; j < 4; j++)
      begin
        adp <= j[0];
        rev <= j[1];
        repeat (3) @(posedge CLK);
        check(obs, dec(w));
      end
      rd(C12, w);
    end
    for (int k = 0; k < 2; k++)
    begin
      w = 16'hE72E | 16'(k << 12);
      wr(AD, C12, w);
      batt_n <= 1'b0;
      repeat (12) @(posedge CLK);
      w = w & ~(16'h0020 | 16'(k << 1));
      check(obs, dec(w));
      rd(C12, w);
      batt_n <= 1'b1;
    end
    $display("control test done");
    wr(AD, `SCRB_CMD_CHG_CUR, 16'h0400);
    wr(AD, `SCRB_CMD_CHG_VLIM, 16'h2000);
    wr(AD, C12, 16'hA70E);
    check({chg, wds, cur}, {2'b10, 16'h0400});
    i = 0;
    while (wds !== 1'b1 && i < 1000)
    begin
      @(posedge CLK);
      i++;
    end
    check(i > 300 && i < 1000, 1'b1);
    if (i == 1000)
      end_sim();
    check({chg, cur}, 17'h00000);
    rd(`SCRB_CMD_CHG_CUR, 16'h0000);
    wr(AD, C12, 16'h870E);
    wr(AD, `SCRB_CMD_CHG_CUR, 16'h0400);
    check({chg, wds, vlt}, {2'b10, 16'h2000});
    wr(AD, C12, 16'h870F);
    check(chg, 1'b0);
    $display("watchdog test done");
    @(posedge CLK);
    check(exp_q.size(), 20'h00000);
    end_sim();
  end
endmodule
`default_nettype wire

// ### verilog/scrb_defines.vh
/*
 register bank constants: command codes, field positions, reset values,
 bus address and watchdog timing.
 assumes inclusion by bare name from the design files.
*/
`ifndef SCRB_DEFINES_VH
`define SCRB_DEFINES_VH
`define SCRB_SLAVE_ADDR 7'h09
`define SCRB_CMD_CTRL_A 8'h12
`define SCRB_CMD_CHG_CUR 8'h14
`define SCRB_CMD_CHG_VLIM 8'h15
`define SCRB_CMD_STATE 8'h20
`define SCRB_CMD_THR_STATE 8'h21
`define SCRB_CMD_IN_LIMIT 8'h22
`define SCRB_CMD_VBUS_ADC 8'h23
`define SCRB_CMD_BATTERY_CURRENT_MONITOR_ADC 8'h24
`define SCRB_CMD_IIN_ADC 8'h25
`define SCRB_CMD_VSYS_ADC 8'h26
`define SCRB_CMD_CTRL_B 8'h30
`define SCRB_CMD_CTRL_C 8'h31
`define SCRB_CMD_CTRL_D 8'h32
`define SCRB_CMD_THR_A 8'h33
`define SCRB_CMD_THR_B 8'h34
`define SCRB_CMD_ADC_CFG 8'h35
`define SCRB_CMD_CTRL_E 8'h36
`define SCRB_CMD_REV_V 8'h3B
`define SCRB_CMD_REV_I 8'h3C
`define SCRB_CMD_VIN_FLOOR 8'h3D
`define SCRB_CMD_VSYS_FLOOR 8'h3E
`define SCRB_CMD_HOST_ILIM 8'h3F
`define SCRB_CMD_MAKER 8'hFE
`define SCRB_CMD_PART 8'hFF
`define SCRB_CTRL_A_RST 16'hE70E
`define SCRB_ZERO_RST 16'h0000
`define SCRB_B_LOWPWR 15
`define SCRB_B_WDT_HI 14
`define SCRB_B_WDT_LO 13
`define SCRB_B_ILIM_AUTO 12
`define SCRB_B_REV_PG 11
`define SCRB_B_AUDIO 10
`define SCRB_B_RATE 9
`define SCRB_B_RIPPLE 8
`define SCRB_B_SHORT_OFF 6
`define SCRB_B_CALDIS 5
`define SCRB_B_AGAIN 4
`define SCRB_B_BGAIN 3
`define SCRB_B_LDO 2
`define SCRB_B_IREG 1
`define SCRB_B_BLOCK 0
`define SCRB_WDT_S1 8'h05
`define SCRB_WDT_S2 8'h4D
`define SCRB_WDT_S3 8'h99
`define SCRB_CLK_HZ 100000000
`endif

// ### verilog/scrb_sync.v
/*
 three flip-flop synchroniser for one pin; the output changes only once
 the second and third stages agree.
 assumes CLK domain; pin is asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module scrb_sync
#(
  parameter INIT = 1'b1
)
(
  // clocking
  input wire clk,
  input wire rst_b,
  input wire ce,
  // pin and result
  input wire din,
  output reg dout
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      dout <= INIT;
    end
    else if (ce)
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // a stage-2/3 mismatch is a possible glitch, hold old value
      if (s2_reg == s3_reg)
        dout <= s3_reg;
    end
  end
endmodule
`default_nettype wire

// ### verilog/scrb_top.v
/*
 SMBus slave register bank of a charge controller: word read and word
 write, control word A decoded to pins, watchdog on charge settings.
 assumes SCL and SDA are slow pins sampled by CLK; SDA is open drain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scrb_defines.vh"
module scrb_top
#(
  parameter TICKS_PER_S = `SCRB_CLK_HZ,
  parameter [15:0] MAKER_CODE = 16'h005A, // arbitrary value
  parameter [15:0] PART_CODE = 16'h00A5 // arbitrary value
)
(
  // clocking
  input wire CLK,
  input wire RST_B,
  input wire CE,
  // smbus pins
  input wire SCL_IN,
  input wire SDA_IN,
  output reg SDA_OUT,
  output reg SDA_OE,
  // device state
  input wire BATTERY_PRESENT_N_PIN,
  input wire ADAPTER_PRESENT,
  input wire REVERSE_MODE_ACTIVE,
  input wire [15:0] STATE_FLAGS_IN,
  input wire [15:0] STATE_FLAGS_RC,
  input wire [15:0] THR_FLAGS_IN,
  input wire [15:0] THR_FLAGS_RC,
  input wire [15:0] IN_LIMIT_IN,
  input wire [15:0] VBUS_ADC_IN,
  input wire [15:0] BATTERY_CURRENT_MONITOR_ADC_IN,
  input wire [15:0] IIN_ADC_IN,
  input wire [15:0] VSYS_ADC_IN,
  // decoded controls
  output reg GATE_DRIVE_SUPPLY_EN,
  output reg BATTERY_CURRENT_MONITOR_EN,
  output reg SYSTEM_POWER_MONITOR_EN,
  output reg ADC_EN,
  output reg POWER_GOOD_OUT,
  output reg AUDIO_BAND_AVOID,
  output reg SWITCH_RATE_SELECT,
  output reg BYPASS_RIPPLE_REDUCE,
  output reg SHORT_RETRY_OFF,
  output reg GAUGE_CALIBRATION_DISCHARGE,
  output reg ADAPTER_SENSE_GAIN,
  output reg BATTERY_SENSE_GAIN,
  output reg LINEAR_PRECHARGE_ENABLE,
  output reg INPUT_CURRENT_REGULATION_ON,
  output reg CHARGE_ENABLE,
  output reg WATCHDOG_SUSPENDED,
  output reg [15:0] CHARGE_CURRENT_OUT,
  output reg [15:0] CHARGE_VOLTAGE_OUT
);
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_RX = 6'h02;
  localparam [5:0] ST_ACK = 6'h04;
  localparam [5:0] ST_TX = 6'h08;
  localparam [5:0] ST_MACK = 6'h10;
  localparam [5:0] ST_SKIP = 6'h20;

  wire scl_s;
  wire sda_s;
  wire bat_n_s;
  wire wd_expired;
  reg scl_d_reg;
  reg sda_d_reg;
  reg bat_n_d_reg;
  reg [5:0] state_reg;
  reg [3:0] bit_reg;
  reg [7:0] shift_reg;
  reg [1:0] byte_reg;
  reg rd_dir_reg;
  reg [7:0] cmd_reg;
  reg [7:0] lo_reg;
  reg [15:0] tx_reg;
  integer n;
  reg [15:0] ctrl_a_reg;
  reg [15:0] chg_cur_reg;
  reg [15:0] chg_vlim_reg;
  reg [15:0] rw_reg [0:12];
  reg [15:0] st_hold_reg;
  reg [15:0] thr_hold_reg;
  reg [15:0] rd_data;
  reg [3:0] rw_idx;
  reg rw_hit;
  reg wd_restart_reg;
  reg suspend_reg;
  wire start_c;
  wire stop_c;
  wire scl_rise;
  wire scl_fall;
  wire bat_fall;

  scrb_sync #(.INIT(1'b1)) u_scl (.clk(CLK), .rst_b(RST_B), .ce(CE),
    .din(SCL_IN), .dout(scl_s));
  scrb_sync #(.INIT(1'b1)) u_sda (.clk(CLK), .rst_b(RST_B), .ce(CE),
    .din(SDA_IN), .dout(sda_s));
  scrb_sync #(.INIT(1'b1)) u_bat (.clk(CLK), .rst_b(RST_B), .ce(CE),
    .din(BATTERY_PRESENT_N_PIN), .dout(bat_n_s));

  scrb_wdog #(.TICKS_PER_S(TICKS_PER_S)) u_wdog (.clk(CLK), .rst_b(RST_B),
    .ce(CE), .sel(ctrl_a_reg[`SCRB_B_WDT_HI:`SCRB_B_WDT_LO]),
    .restart(wd_restart_reg), .expired(wd_expired));

  assign start_c = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_c = scl_s && scl_d_reg && !sda_d_reg && sda_s;
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign bat_fall = bat_n_d_reg && !bat_n_s;

  ////////////////////////////////////////////////////////////////////////
  // general-purpose read/write registers kept as a small array
  always @*
  begin
    rw_hit = 1'b1;
    case (cmd_reg)
      `SCRB_CMD_CTRL_B: rw_idx = 4'h0;
      `SCRB_CMD_CTRL_C: rw_idx = 4'h1;
      `SCRB_CMD_CTRL_D: rw_idx = 4'h2;
      `SCRB_CMD_THR_A: rw_idx = 4'h3;
      `SCRB_CMD_THR_B: rw_idx = 4'h4;
      `SCRB_CMD_ADC_CFG: rw_idx = 4'h5;
      `SCRB_CMD_CTRL_E: rw_idx = 4'h6;
      `SCRB_CMD_REV_V: rw_idx = 4'h7;
      `SCRB_CMD_REV_I: rw_idx = 4'h8;
      `SCRB_CMD_VIN_FLOOR: rw_idx = 4'h9;
      `SCRB_CMD_VSYS_FLOOR: rw_idx = 4'hA;
      `SCRB_CMD_HOST_ILIM: rw_idx = 4'hB;
      default:
      begin
        rw_idx = 4'hC;
        rw_hit = 1'b0;
      end
    endcase
  end

  always @*
  begin
    case (cmd_reg)
      `SCRB_CMD_CTRL_A: rd_data = ctrl_a_reg;
      `SCRB_CMD_CHG_CUR: rd_data = chg_cur_reg;
      `SCRB_CMD_CHG_VLIM: rd_data = chg_vlim_reg;
      `SCRB_CMD_STATE: rd_data = STATE_FLAGS_IN | st_hold_reg;
      `SCRB_CMD_THR_STATE: rd_data = THR_FLAGS_IN | thr_hold_reg;
      `SCRB_CMD_IN_LIMIT: rd_data = IN_LIMIT_IN;
      `SCRB_CMD_VBUS_ADC: rd_data = VBUS_ADC_IN;
      `SCRB_CMD_BATTERY_CURRENT_MONITOR_ADC: rd_data = BATTERY_CURRENT_MONITOR_ADC_IN;
      `SCRB_CMD_IIN_ADC: rd_data = IIN_ADC_IN;
      `SCRB_CMD_VSYS_ADC: rd_data = VSYS_ADC_IN;
      `SCRB_CMD_MAKER: rd_data = MAKER_CODE;
      `SCRB_CMD_PART: rd_data = PART_CODE;
      default: rd_data = rw_hit ? rw_reg[rw_idx] : `SCRB_ZERO_RST;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // bus engine and register writes
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      bat_n_d_reg <= 1'b1;
      state_reg <= ST_IDLE;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      byte_reg <= 2'h0;
      rd_dir_reg <= 1'b0;
      cmd_reg <= 8'h00;
      lo_reg <= 8'h00;
      tx_reg <= 16'h0000;
      for (n = 0; n < 13; n = n + 1)
        rw_reg[n] <= `SCRB_ZERO_RST;
      ctrl_a_reg <= `SCRB_CTRL_A_RST;
      chg_cur_reg <= `SCRB_ZERO_RST;
      chg_vlim_reg <= `SCRB_ZERO_RST;
      st_hold_reg <= `SCRB_ZERO_RST;
      thr_hold_reg <= `SCRB_ZERO_RST;
      wd_restart_reg <= 1'b0;
      suspend_reg <= 1'b0;
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
    end
    else if (CE)
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      bat_n_d_reg <= bat_n_s;
      wd_restart_reg <= 1'b0;
      // capture clear-on-read events; set wins over read clear
      st_hold_reg <= st_hold_reg | STATE_FLAGS_RC;
      thr_hold_reg <= thr_hold_reg | THR_FLAGS_RC;
      if (wd_expired)
      begin
        chg_cur_reg <= `SCRB_ZERO_RST;
        suspend_reg <= 1'b1;
      end
      if (bat_fall && ctrl_a_reg[`SCRB_B_ILIM_AUTO])
        ctrl_a_reg[`SCRB_B_IREG] <= 1'b0;
      if (bat_fall)
        ctrl_a_reg[`SCRB_B_CALDIS] <= 1'b0;
      if (start_c)
      begin
        // start and repeated start both restart the address
        state_reg <= ST_RX;
        bit_reg <= 4'h0;
        byte_reg <= 2'h0;
        SDA_OE <= 1'b0;
      end
      else if (stop_c)
      begin
        state_reg <= ST_IDLE;
        SDA_OE <= 1'b0;
      end
      else
      begin
        case (state_reg)
          ST_RX:
          begin
            if (scl_rise)
            begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_reg <= bit_reg + 4'h1;
            end
            else if (scl_fall && bit_reg == 4'h8)
            begin
              bit_reg <= 4'h0;
              state_reg <= ST_ACK;
              if (byte_reg == 2'h0)
              begin
                if (shift_reg[7:1] != `SCRB_SLAVE_ADDR)
                  state_reg <= ST_SKIP;
                // only a read of that word clears its flags
                else if (shift_reg[0] && cmd_reg == `SCRB_CMD_STATE)
                  st_hold_reg <= STATE_FLAGS_RC;
                else if (shift_reg[0] && cmd_reg == `SCRB_CMD_THR_STATE)
                  thr_hold_reg <= THR_FLAGS_RC;
                rd_dir_reg <= shift_reg[0];
                tx_reg <= rd_data;
                byte_reg <= 2'h1;
              end
              else if (byte_reg == 2'h1)
              begin
                cmd_reg <= shift_reg;
                byte_reg <= 2'h2;
              end
              else if (byte_reg == 2'h2)
              begin
                lo_reg <= shift_reg;
                byte_reg <= 2'h3;
              end
              else
              begin
                if (cmd_reg == `SCRB_CMD_CTRL_A)
                begin
                  ctrl_a_reg <= {shift_reg, lo_reg};
                  wd_restart_reg <= 1'b1;
                end
                else if (cmd_reg == `SCRB_CMD_CHG_CUR ||
                         cmd_reg == `SCRB_CMD_CHG_VLIM)
                begin
                  if (cmd_reg == `SCRB_CMD_CHG_CUR)
                    chg_cur_reg <= {shift_reg, lo_reg};
                  else
                    chg_vlim_reg <= {shift_reg, lo_reg};
                  // restart and resume on new values
                  wd_restart_reg <= 1'b1;
                  suspend_reg <= 1'b0;
                end
                else if (rw_hit)
                  rw_reg[rw_idx] <= {shift_reg, lo_reg};
                byte_reg <= 2'h0;
              end
              SDA_OUT <= 1'b0;
              SDA_OE <= shift_reg[7:1] == `SCRB_SLAVE_ADDR ||
                byte_reg != 2'h0;
            end
          end
          ST_ACK:
          begin
            if (scl_fall)
            begin
              if (rd_dir_reg && byte_reg == 2'h1)
              begin
                state_reg <= ST_TX;
                SDA_OUT <= 1'b0;
                SDA_OE <= ~tx_reg[7];
                tx_reg <= {tx_reg[15:8], tx_reg[6:0], 1'b0};
                bit_reg <= 4'h1;
              end
              else
              begin
                state_reg <= ST_RX;
                SDA_OE <= 1'b0;
              end
            end
          end
          ST_TX:
          begin
            if (scl_fall)
            begin
              if (bit_reg == 4'h8)
              begin
                state_reg <= ST_MACK;
                SDA_OE <= 1'b0;
                bit_reg <= 4'h0;
              end
              else
              begin
                SDA_OE <= ~tx_reg[7];
                tx_reg <= {tx_reg[15:8], tx_reg[6:0], 1'b0};
                bit_reg <= bit_reg + 4'h1;
              end
            end
          end
          ST_MACK:
          begin
            // master ack continues, nack ends the word
            if (scl_rise)
              shift_reg[0] <= sda_s;
            else if (scl_fall)
            begin
              if (!shift_reg[0] && byte_reg == 2'h1)
              begin
                byte_reg <= 2'h2;
                state_reg <= ST_TX;
                SDA_OE <= ~tx_reg[15];
                tx_reg <= {8'h00, tx_reg[14:8], 1'b0};
                bit_reg <= 4'h1;
              end
              else
                state_reg <= ST_SKIP;
            end
          end
          ST_SKIP:
            SDA_OE <= 1'b0;
          default:
            state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decoded control outputs
  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      GATE_DRIVE_SUPPLY_EN <= 1'b1;
      BATTERY_CURRENT_MONITOR_EN <= 1'b1;
      SYSTEM_POWER_MONITOR_EN <= 1'b1;
      ADC_EN <= 1'b1;
      POWER_GOOD_OUT <= 1'b0;
      AUDIO_BAND_AVOID <= 1'b1;
      SWITCH_RATE_SELECT <= 1'b1;
      BYPASS_RIPPLE_REDUCE <= 1'b1;
      SHORT_RETRY_OFF <= 1'b0;
      GAUGE_CALIBRATION_DISCHARGE <= 1'b0;
      ADAPTER_SENSE_GAIN <= 1'b0;
      BATTERY_SENSE_GAIN <= 1'b1;
      LINEAR_PRECHARGE_ENABLE <= 1'b1;
      INPUT_CURRENT_REGULATION_ON <= 1'b1;
      CHARGE_ENABLE <= 1'b0;
      WATCHDOG_SUSPENDED <= 1'b0;
      CHARGE_CURRENT_OUT <= 16'h0000;
      CHARGE_VOLTAGE_OUT <= 16'h0000;
    end
    else if (CE)
    begin
      GATE_DRIVE_SUPPLY_EN <= !(ctrl_a_reg[`SCRB_B_LOWPWR] &&
        !ADAPTER_PRESENT);
      BATTERY_CURRENT_MONITOR_EN <= !(ctrl_a_reg[`SCRB_B_LOWPWR] &&
        !ADAPTER_PRESENT);
      SYSTEM_POWER_MONITOR_EN <= !(ctrl_a_reg[`SCRB_B_LOWPWR] &&
        !ADAPTER_PRESENT);
      ADC_EN <= !(ctrl_a_reg[`SCRB_B_LOWPWR] && !ADAPTER_PRESENT);
      POWER_GOOD_OUT <= ctrl_a_reg[`SCRB_B_REV_PG] && REVERSE_MODE_ACTIVE;
      AUDIO_BAND_AVOID <= ctrl_a_reg[`SCRB_B_AUDIO];
      SWITCH_RATE_SELECT <= ctrl_a_reg[`SCRB_B_RATE];
      BYPASS_RIPPLE_REDUCE <= ctrl_a_reg[`SCRB_B_RIPPLE];
      SHORT_RETRY_OFF <= ctrl_a_reg[`SCRB_B_SHORT_OFF];
      GAUGE_CALIBRATION_DISCHARGE <= ctrl_a_reg[`SCRB_B_CALDIS];
      ADAPTER_SENSE_GAIN <= ctrl_a_reg[`SCRB_B_AGAIN];
      BATTERY_SENSE_GAIN <= ctrl_a_reg[`SCRB_B_BGAIN];
      LINEAR_PRECHARGE_ENABLE <= ctrl_a_reg[`SCRB_B_LDO];
      INPUT_CURRENT_REGULATION_ON <= ctrl_a_reg[`SCRB_B_IREG];
      // charge only when unblocked with valid settings
      CHARGE_ENABLE <= !ctrl_a_reg[`SCRB_B_BLOCK] && !suspend_reg &&
        chg_cur_reg != 16'h0000 && chg_vlim_reg != 16'h0000;
      WATCHDOG_SUSPENDED <= suspend_reg;
      CHARGE_CURRENT_OUT <= chg_cur_reg;
      CHARGE_VOLTAGE_OUT <= chg_vlim_reg;
    end
  end
endmodule
`default_nettype wire

// ### verilog/scrb_wdog.v
/*
 supervision watchdog: counts one-second ticks up to the selected limit
 and pulses expired once.
 assumes a restart pulse from the register bank on qualifying writes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scrb_defines.vh"
module scrb_wdog
#(
  parameter TICKS_PER_S = `SCRB_CLK_HZ
)
(
  // clocking
  input wire clk,
  input wire rst_b,
  input wire ce,
  // control
  input wire [1:0] sel,
  input wire restart,
  output reg expired
);
  reg [31:0] pre_reg;
  reg [7:0] sec_reg;
  reg [7:0] limit;
  reg done_reg;

  always @*
  begin
    case (sel)
      2'h1: limit = `SCRB_WDT_S1;
      2'h2: limit = `SCRB_WDT_S2;
      2'h3: limit = `SCRB_WDT_S3;
      default: limit = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pre_reg <= 32'h00000000;
      sec_reg <= 8'h00;
      done_reg <= 1'b0;
      expired <= 1'b0;
    end
    else if (ce)
    begin
      expired <= 1'b0;
      if (restart || sel == 2'h0)
      begin
        pre_reg <= 32'h00000000;
        sec_reg <= 8'h00;
        done_reg <= 1'b0;
      end
      else if (!done_reg)
      begin
        if (pre_reg == TICKS_PER_S - 1)
        begin
          pre_reg <= 32'h00000000;
          sec_reg <= sec_reg + 8'h01;
          if (sec_reg + 8'h01 == limit)
          begin
            done_reg <= 1'b1;
            expired <= 1'b1;
          end
        end
        else
          pre_reg <= pre_reg + 32'h00000001;
      end
    end
  end
endmodule
`default_nettype wire
